// file: logic/pipd_params.svh
// constants for the interrupt and power-down register block
`ifndef PIPD_PARAMS_SVH
`define PIPD_PARAMS_SVH

// management register addresses
`define PIPD_REG_INTR_CTL 5'h16
`define PIPD_REG_INTR_FLAGS 5'h17
`define PIPD_REG_PD_CTL 5'h18

// interrupt control word fields
`define PIPD_CTL_OUT_EN 15
`define PIPD_CTL_RD_CLR 14
`define PIPD_CTL_POL 13
`define PIPD_CTL_AUTO_CLR 12
`define PIPD_CTL_RESETUP 11
`define PIPD_CTL_RST 16'h0000

// event flags, bit 10 down to 0
`define PIPD_NUM_FLAGS 11
`define PIPD_FL_SLP_WAKE 10
`define PIPD_FL_SLP_ENTRY 9
`define PIPD_FL_AN_DONE 8
`define PIPD_FL_LINK_DOWN 2
`define PIPD_FL_REMOTE_FAULT 1
`define PIPD_FL_LINK_UP 0

// fifo and power-down word fields
`define PIPD_PD_THR_MSB 15
`define PIPD_PD_THR_LSB 12
`define PIPD_PD_SLP_EN 8
`define PIPD_PD_PLL 7
`define PIPD_PD_RX 6
`define PIPD_PD_TX 5
`define PIPD_PD_CDR 4
`define PIPD_PD_RW_MASK 16'hfff0
`define PIPD_PD_RST 16'h2000
`define PIPD_THR_BIAS 6'h03

// management frame
`define PIPD_PRE_LEN 6'h20
`define PIPD_OP_RD 2'b10
`define PIPD_OP_WR 2'b01
`define PIPD_OP_LAST 4'h1
`define PIPD_ADDR_LAST 4'h9
`define PIPD_DATA_LAST 4'hf

`endif

// file: logic/pipd_pkg.sv
// types shared by the interrupt and power-down register block
package pipd_pkg;

    typedef logic [15:0] pipd_word_t;

    typedef enum logic [2:0] {
        pipd_m_pre = 3'b000,
        pipd_m_start = 3'b001,
        pipd_m_op = 3'b010,
        pipd_m_addr = 3'b011,
        pipd_m_ta = 3'b100,
        pipd_m_data = 3'b101
    } pipd_mstate_t;

    typedef enum logic [0:0] {
        pipd_p_awake = 1'b0,
        pipd_p_sleep = 1'b1
    } pipd_pstate_t;

    typedef struct packed {
        logic jabber;
        logic rx_err;
        logic page_rx;
        logic pd_fault;
        logic partner_ack;
        logic link_down;
        logic remote_fault;
        logic link_up;
    } pipd_events_t;

    typedef struct packed {
        logic pll;
        logic rx;
        logic tx_dac;
        logic cdr;
    } pipd_sleep_t;

endpackage : pipd_pkg

// file: logic/pipd_flag_cell.sv
// one sticky event flag with read-clear and auto-clear
`timescale 1ns/1ns
`default_nettype none

module pipd_flag_cell (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // event and clear controls
    input wire logic cond,
    input wire logic auto_clr_en,
    input wire logic rd_clr,
    // flag
    output logic flag
);

    logic flag_r;
    logic flag_nxt;

    // a live condition always wins over either clear
    assign flag_nxt = cond | (flag_r & ~rd_clr & ~auto_clr_en);
    assign flag = flag_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

endmodule : pipd_flag_cell

`default_nettype wire

// file: logic/pipd_top.sv
// interrupt flags, interrupt output and deep power-down control behind the management bus
`timescale 1ns/1ns
`default_nettype none
`include "pipd_params.svh"

// Notes on behaviour
// - eight low interrupt enables, reset disabled
// - jabber sets flag bit 7
// - receive error sets flag bit 6
// - page received sets flag bit 5
// - parallel detect fault sets flag bit 4
// - partner acknowledge sets flag bit 3
// - link lost sets flag bit 2
// - remote fault sets flag bit 1
// - link established sets flag bit 0
// - power-down wake sets flag bit 10
// - power-down entry bit 9, negotiation done 8
// - fifo threshold field, (n+3)*2, resets 2
// - sleep on broken link only when enabled
// - receive block sleeps when bit 6 set
// - transmit dac sleeps when bit 5 set
// - clock recovery sleeps when bit 4 set
// - polarity bit picks interrupt active level
// - reading flags clears them when enabled
// - auto-clear drops flag once condition gone
// - enables for wake, entry, negotiation done
module pipd_top import pipd_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // management serial bus
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    input wire logic [4:0] phy_addr,
    // line events
    input wire pipd_events_t ev,
    input wire logic an_done,
    input wire logic link_ok,
    // interrupt and power control
    output logic irq,
    output pipd_sleep_t sleep,
    output logic deep_power_down,
    output logic [5:0] fifo_half_thr
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    pipd_mstate_t mst_r;
    pipd_mstate_t mst_nxt;
    logic [5:0] pre_cnt_r;
    logic [5:0] pre_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [1:0] op_r;
    logic [1:0] op_nxt;
    logic [9:0] adr_sh_r;
    logic [9:0] adr_nxt;
    logic [15:0] wr_sh_r;
    logic [15:0] wsh_nxt;
    pipd_word_t rd_sh_r;
    pipd_word_t rsh_nxt;
    logic hit_r;
    logic hit_nxt;
    logic mdio_o_r;
    logic mo_nxt;
    logic mdio_oe_r;
    logic moe_nxt;
    logic wr_go;
    logic rd_go;
    logic mdc_prev_r;

    pipd_word_t ctl_r;
    pipd_word_t pd_r;
    pipd_pstate_t pst_r;
    pipd_pstate_t pst_nxt;
    logic [`PIPD_NUM_FLAGS-1:0] flags;
    logic irq_r;
    pipd_sleep_t sleep_r;
    logic [5:0] thr_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    // management frame decode

    wire mdc_rise = mdc & ~mdc_prev_r;
    wire pre_full = (pre_cnt_r == `PIPD_PRE_LEN);
    wire op_ok = (op_r == `PIPD_OP_RD) || (op_r == `PIPD_OP_WR);
    wire [4:0] regad_now = {adr_sh_r[3:0], mdio_i};
    wire phy_hit_now = (adr_sh_r[8:4] == phy_addr);
    wire rd_mode = hit_r && (op_r == `PIPD_OP_RD);
    wire [4:0] wadr = adr_sh_r[4:0];
    wire [15:0] wr_word = {wr_sh_r[14:0], mdio_i};
    wire sel_ctl_rd = (regad_now == `PIPD_REG_INTR_CTL);
    wire sel_flg_rd = (regad_now == `PIPD_REG_INTR_FLAGS);
    wire sel_pd_rd = (regad_now == `PIPD_REG_PD_CTL);
    wire wr_ctl = wr_go && (wadr == `PIPD_REG_INTR_CTL);
    wire wr_pd = wr_go && (wadr == `PIPD_REG_PD_CTL);
    wire [15:0] flag_word = {{(16-`PIPD_NUM_FLAGS){1'b0}}, flags};
    // unmapped addresses answer with zero so the bus never floats mid-frame
    wire [15:0] rd_word = sel_ctl_rd ? ctl_r :
                          sel_flg_rd ? flag_word :
                          sel_pd_rd ? (pd_r & `PIPD_PD_RW_MASK) : 16'h0000;

    always_comb begin
        mst_nxt = mst_r;
        pre_nxt = pre_cnt_r;
        cnt_nxt = cnt_r;
        op_nxt = op_r;
        adr_nxt = adr_sh_r;
        wsh_nxt = wr_sh_r;
        rsh_nxt = rd_sh_r;
        hit_nxt = hit_r;
        mo_nxt = mdio_o_r;
        moe_nxt = mdio_oe_r;
        wr_go = 1'b0;
        rd_go = 1'b0;
        if (mdc_rise) begin
            case (mst_r)
                pipd_m_pre: begin
                    if (mdio_i) begin
                        pre_nxt = pre_full ? pre_cnt_r : pre_cnt_r + 6'h01;
                    end else begin
                        pre_nxt = 6'h00;
                        if (pre_full) begin
                            mst_nxt = pipd_m_start;
                        end
                    end
                end
                pipd_m_start: begin
                    cnt_nxt = 4'h0;
                    mst_nxt = mdio_i ? pipd_m_op : pipd_m_pre;
                end
                pipd_m_op: begin
                    op_nxt = {op_r[0], mdio_i};
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == `PIPD_OP_LAST) begin
                        cnt_nxt = 4'h0;
                        mst_nxt = pipd_m_addr;
                    end
                end
                pipd_m_addr: begin
                    adr_nxt = {adr_sh_r[8:0], mdio_i};
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == `PIPD_ADDR_LAST) begin
                        cnt_nxt = 4'h0;
                        hit_nxt = phy_hit_now;
                        mst_nxt = op_ok ? pipd_m_ta : pipd_m_pre;
                        if (op_ok && phy_hit_now && (op_r == `PIPD_OP_RD)) begin
                            rd_go = 1'b1;
                            rsh_nxt = rd_word;
                        end
                    end
                end
                pipd_m_ta: begin
                    if (cnt_r == 4'h0) begin
                        cnt_nxt = 4'h1;
                        if (rd_mode) begin
                            moe_nxt = 1'b1;
                            mo_nxt = 1'b0;
                        end
                    end else begin
                        cnt_nxt = 4'h0;
                        mst_nxt = pipd_m_data;
                        if (rd_mode) begin
                            mo_nxt = rd_sh_r[15];
                            rsh_nxt = {rd_sh_r[14:0], 1'b0};
                        end
                    end
                end
                pipd_m_data: begin
                    cnt_nxt = cnt_r + 4'h1;
                    wsh_nxt = wr_word;
                    if (cnt_r == `PIPD_DATA_LAST) begin
                        mst_nxt = pipd_m_pre;
                        pre_nxt = 6'h00;
                        moe_nxt = 1'b0;
                        mo_nxt = 1'b0;
                        wr_go = hit_r && (op_r == `PIPD_OP_WR);
                    end else if (rd_mode) begin
                        mo_nxt = rd_sh_r[15];
                        rsh_nxt = {rd_sh_r[14:0], 1'b0};
                    end
                end
                default: begin
                    mst_nxt = pipd_m_pre;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mst_r <= pipd_m_pre;
            pre_cnt_r <= 6'h00;
            cnt_r <= 4'h0;
            op_r <= 2'b00;
            adr_sh_r <= 10'h000;
            wr_sh_r <= 16'h0000;
            rd_sh_r <= 16'h0000;
            hit_r <= 1'b0;
            mdio_o_r <= 1'b0;
            mdio_oe_r <= 1'b0;
            mdc_prev_r <= 1'b0;
        end else begin
            mst_r <= mst_nxt;
            pre_cnt_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            op_r <= op_nxt;
            adr_sh_r <= adr_nxt;
            wr_sh_r <= wsh_nxt;
            rd_sh_r <= rsh_nxt;
            hit_r <= hit_nxt;
            mdio_o_r <= mo_nxt;
            mdio_oe_r <= moe_nxt;
            mdc_prev_r <= mdc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_r <= `PIPD_CTL_RST;
            pd_r <= `PIPD_PD_RST;
        end else begin
            if (wr_ctl) begin
                ctl_r <= wr_word;
            end
            if (wr_pd) begin
                pd_r <= wr_word & `PIPD_PD_RW_MASK;
            end
        end
    end

    property p_ctl_write;
        wr_ctl |=> (ctl_r == $past(wr_word));
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("enable word not stored");

    property p_en_high;
        wr_ctl |=> (ctl_r[10:8] == $past(wr_word[10:8]));
    endproperty
    a_en_high: assert property (p_en_high) else $error("high enables not stored");

    ////////////////////////////////////////////////////////////////////////////
    // deep power-down sequencing

    // wake is taken as link regained or the feature turned off by software
    wire entry_go = (pst_r == pipd_p_awake) && pd_r[`PIPD_PD_SLP_EN] && !link_ok;
    wire wake_go = (pst_r == pipd_p_sleep) && (link_ok || !pd_r[`PIPD_PD_SLP_EN]);
    wire in_sleep = (pst_r == pipd_p_sleep);
    wire [5:0] thr_sum = {2'b00, pd_r[`PIPD_PD_THR_MSB:`PIPD_PD_THR_LSB]} + `PIPD_THR_BIAS;
    wire [5:0] thr_nxt = {thr_sum[4:0], 1'b0};

    assign pst_nxt = entry_go ? pipd_p_sleep : (wake_go ? pipd_p_awake : pst_r);

    always_ff @(posedge clk) begin
        if (rst) begin
            pst_r <= pipd_p_awake;
            sleep_r <= '0;
            thr_r <= 6'h00;
        end else begin
            pst_r <= pst_nxt;
            sleep_r.pll <= in_sleep & pd_r[`PIPD_PD_PLL];
            sleep_r.rx <= in_sleep & pd_r[`PIPD_PD_RX];
            sleep_r.tx_dac <= in_sleep & pd_r[`PIPD_PD_TX];
            sleep_r.cdr <= in_sleep & pd_r[`PIPD_PD_CDR];
            thr_r <= thr_nxt;
        end
    end

    sequence s_slp_enter;
        entry_go;
    endsequence
    sequence s_asleep_flagged;
        in_sleep && flags[`PIPD_FL_SLP_ENTRY];
    endsequence
    property p_slp_enter;
        s_slp_enter |=> s_asleep_flagged;
    endproperty
    a_slp_enter: assert property (p_slp_enter) else $error("no sleep entry");

    property p_slp_gated;
        (!in_sleep && !pd_r[`PIPD_PD_SLP_EN]) |=> !in_sleep;
    endproperty
    a_slp_gated: assert property (p_slp_gated) else $error("sleep while disabled");

    property p_slp_wake;
        wake_go |=> (!in_sleep && flags[`PIPD_FL_SLP_WAKE]);
    endproperty
    a_slp_wake: assert property (p_slp_wake) else $error("wake not flagged");

    property p_sleep_out;
        1'b1 |=> (sleep == ($past(in_sleep) ? $past({pd_r[7], pd_r[6], pd_r[5], pd_r[4]}) : 4'h0));
    endproperty
    a_sleep_out: assert property (p_sleep_out) else $error("sleep outputs wrong");

    property p_thr;
        1'b1 |=> (fifo_half_thr == ($past({2'b00, pd_r[15:12]}) + 6'h03) * 6'h02);
    endproperty
    a_thr: assert property (p_thr) else $error("fifo threshold wrong");

    ////////////////////////////////////////////////////////////////////////////
    // event flags

    wire [`PIPD_NUM_FLAGS-1:0] cond = {wake_go, entry_go, an_done, ev};
    // a read that lands with a live condition leaves the flag set
    wire rd_clr_p = rd_go && sel_flg_rd && ctl_r[`PIPD_CTL_RD_CLR];

    for (genvar i = 0; i < `PIPD_NUM_FLAGS; i++) begin : g_flag
        pipd_flag_cell u_cell (
            .clk(clk),
            .rst(rst),
            .cond(cond[i]),
            .auto_clr_en(ctl_r[`PIPD_CTL_AUTO_CLR]),
            .rd_clr(rd_clr_p),
            .flag(flags[i])
        );

        property p_flag_set;
            cond[i] |=> flags[i];
        endproperty
        a_flag_set: assert property (p_flag_set) else $error("event did not set flag");
    end

    property p_link_up_auto;
        (flags[0] && ctl_r[`PIPD_CTL_AUTO_CLR] && !cond[0]) |=> !flags[0];
    endproperty
    a_link_up_auto: assert property (p_link_up_auto) else $error("auto-clear failed");

    property p_link_down_hold;
        (flags[2] && !ctl_r[`PIPD_CTL_AUTO_CLR] && !rd_clr_p && !cond[2]) |=> flags[2];
    endproperty
    a_link_down_hold: assert property (p_link_down_hold) else $error("flag lost");

    property p_rd_clr;
        (rd_clr_p && !cond[1]) |=> !flags[1] && (rd_sh_r[1] == $past(flags[1]));
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("read-clear failed");

    property p_rd_keep;
        (rd_go && !ctl_r[`PIPD_CTL_RD_CLR] && flags[8] && !ctl_r[`PIPD_CTL_AUTO_CLR]) |=> flags[8];
    endproperty
    a_rd_keep: assert property (p_rd_keep) else $error("read cleared flag");

    ////////////////////////////////////////////////////////////////////////////
    // interrupt output

    wire irq_act = ctl_r[`PIPD_CTL_OUT_EN] && |(flags & ctl_r[`PIPD_NUM_FLAGS-1:0]);

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_r <= 1'b1;
        end else begin
            irq_r <= ctl_r[`PIPD_CTL_POL] ? irq_act : ~irq_act;
        end
    end

    property p_irq_level;
        1'b1 |=> (irq == ($past(irq_act) ~^ $past(ctl_r[`PIPD_CTL_POL])));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    property p_irq_gate;
        (!ctl_r[`PIPD_CTL_OUT_EN] || ((flags & ctl_r[10:0]) == 11'h000)) |=>
            (irq == !$past(ctl_r[`PIPD_CTL_POL]));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign mdio_o = mdio_o_r;
    assign mdio_oe = mdio_oe_r;
    assign irq = irq_r;
    assign sleep = sleep_r;
    assign deep_power_down = pst_r;
    assign fifo_half_thr = thr_r;

endmodule : pipd_top

`default_nettype wire

// file: test/pipd_sta_model.sv
// station management model driving the management serial bus
`timescale 1ns/1ns
`default_nettype none
`include "pipd_params.svh"

module pipd_sta_model import pipd_pkg::*; (
    // clock
    input wire logic clk,
    // device side of the management line
    input wire logic dev_o,
    input wire logic dev_oe,
    // management clock and resolved line
    output var logic mdc,
    output wire logic mdio
);
    logic sta_o;
    logic sta_oe;
    // clk cycles per mdc phase; the bench raises it to run a slow frame
    int half = 2;

    // pull-up holds the line high when nobody drives it
    assign mdio = dev_oe ? dev_o : (sta_oe ? sta_o : 1'b1);

    initial begin
        mdc = 1'b0;
        sta_o = 1'b1;
        sta_oe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one bit: line set while mdc is low, sampled just before mdc rises
    task automatic step(input logic drv, input logic val, output logic seen);
        sta_oe = drv;
        sta_o = val;
        repeat (half) @(posedge clk);
        #1 seen = mdio;
        mdc = 1'b1;
        repeat (half) @(posedge clk);
        #1 mdc = 1'b0;
    endtask : step

    // mdc stands still between frames, so each frame brings a full preamble
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input pipd_word_t wd, output pipd_word_t rd);
        logic s;
        logic [13:0] hdr;
        hdr = {2'b01, op, pa, ra};
        rd = 16'h0000;
        for (int i = 0; i < 32; i++) step(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) step(1'b1, hdr[i], s);
        if (op == `PIPD_OP_RD) begin
            step(1'b0, 1'b1, s);
            step(1'b0, 1'b1, s);
            for (int i = 15; i >= 0; i--) begin
                step(1'b0, 1'b1, s);
                rd[i] = s;
            end
        end else begin
            step(1'b1, 1'b1, s);
            step(1'b1, 1'b0, s);
            for (int i = 15; i >= 0; i--) step(1'b1, wd[i], s);
        end
        sta_oe = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : frame
endmodule : pipd_sta_model
`default_nettype wire

// file: test/pipd_top_tb.sv
// self-checking bench for the interrupt and power-down register block
`timescale 1ns/1ns
`default_nettype none
`include "pipd_params.svh"

module pipd_top_tb import pipd_pkg::*; ();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mdc;
    wire logic mdio;
    logic mdio_o;
    logic mdio_oe;
    logic irq;
    logic deep_power_down;
    pipd_events_t ev = '0;
    logic an_done = 1'b0;
    logic link_ok = 1'b1;
    pipd_sleep_t sleep;
    logic [5:0] fifo_half_thr;
    pipd_word_t rd;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #10 clk = ~clk;

    pipd_top u_dut (
        .clk(clk), .rst(rst), .mdc(mdc), .mdio_i(mdio), .mdio_o(mdio_o),
        .mdio_oe(mdio_oe), .phy_addr(5'h01), .ev(ev), .an_done(an_done),
        .link_ok(link_ok), .irq(irq), .sleep(sleep), .deep_power_down(deep_power_down),
        .fifo_half_thr(fifo_half_thr)
    );

    pipd_sta_model u_sta (
        .clk(clk), .dev_o(mdio_o), .dev_oe(mdio_oe), .mdc(mdc), .mdio(mdio)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [4:0] ra, input pipd_word_t d);
        u_sta.frame(`PIPD_OP_WR, 5'h01, ra, d, rd);
    endtask : wr

    task automatic rd_chk(input logic [4:0] ra, input pipd_word_t exp);
        u_sta.frame(`PIPD_OP_RD, 5'h01, ra, 16'h0000, rd);
        check(rd, exp);
    endtask : rd_chk

    // conditions 0..7 are the line events, 8 is negotiation done
    task automatic cond(input int i, input logic v);
        @(posedge clk);
        #1;
        if (i < 8) ev[i] = v; else an_done = v;
    endtask : cond

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        wait_clk(4);
        rst = 1'b0;
        wait_clk(2);
        check({15'h0, irq}, 16'h0001);
        check({10'h0, fifo_half_thr}, 16'h000a);
        check({11'h0, deep_power_down, sleep}, 16'h0000);
        rd_chk(`PIPD_REG_INTR_CTL, 16'h0000);
        rd_chk(`PIPD_REG_INTR_FLAGS, 16'h0000);
        rd_chk(`PIPD_REG_PD_CTL, 16'h2000);
        rd_chk(5'h15, 16'h0000);
        $display("test reset done");

        wr(`PIPD_REG_INTR_CTL, 16'h07ff);
        rd_chk(`PIPD_REG_INTR_CTL, 16'h07ff);
        wr(`PIPD_REG_PD_CTL, 16'hfeff);
        rd_chk(`PIPD_REG_PD_CTL, 16'hfef0);
        check({10'h0, fifo_half_thr}, 16'h0024);
        wr(`PIPD_REG_PD_CTL, 16'h0000);
        check({10'h0, fifo_half_thr}, 16'h0006);
        wr(`PIPD_REG_INTR_FLAGS, 16'h07ff);
        rd_chk(`PIPD_REG_INTR_FLAGS, 16'h0000);
        // another station address must leave the device untouched
        u_sta.frame(`PIPD_OP_WR, 5'h02, `PIPD_REG_INTR_CTL, 16'hffff, rd);
        rd_chk(`PIPD_REG_INTR_CTL, 16'h07ff);
        wr(`PIPD_REG_PD_CTL, 16'h2000);
        $display("test registers done");

        wr(`PIPD_REG_INTR_CTL, 16'h4000);
        for (int i = 0; i < 9; i++) begin
            cond(i, 1'b1);
            cond(i, 1'b0);
            rd_chk(`PIPD_REG_INTR_FLAGS, 16'h0001 << i);
            rd_chk(`PIPD_REG_INTR_FLAGS, 16'h0000);
        end
        $display("test event flags done");

        wr(`PIPD_REG_INTR_CTL, 16'h1000);
        cond(0, 1'b1);
        rd_chk(`PIPD_REG_INTR_FLAGS, 16'h0001);
        cond(0, 1'b0);
        wait_clk(2);
        rd_chk(`PIPD_REG_INTR_FLAGS, 16'h0000);
        wr(`PIPD_REG_INTR_CTL, 16'h0000);
        cond(2, 1'b1);
        cond(2, 1'b0);
        rd_chk(`PIPD_REG_INTR_FLAGS, 16'h0004);
        rd_chk(`PIPD_REG_INTR_FLAGS, 16'h0004);
        $display("test clear modes done");

        check({15'h0, irq}, 16'h0001);
        wr(`PIPD_REG_INTR_CTL, 16'h8004);
        check({15'h0, irq}, 16'h0000);
        wr(`PIPD_REG_INTR_CTL, 16'ha004);
        check({15'h0, irq}, 16'h0001);
        wr(`PIPD_REG_INTR_CTL, 16'ha002);
        check({15'h0, irq}, 16'h0000);
        wr(`PIPD_REG_INTR_CTL, 16'h2004);
        check({15'h0, irq}, 16'h0000);
        wr(`PIPD_REG_INTR_CTL, 16'h4000);
        rd_chk(`PIPD_REG_INTR_FLAGS, 16'h0004);
        $display("test interrupt output done");

        wr(`PIPD_REG_INTR_CTL, 16'hc200);
        link_ok = 1'b0;
        wait_clk(4);
        check({11'h0, deep_power_down, sleep}, 16'h0000);
        check({15'h0, irq}, 16'h0001);
        wr(`PIPD_REG_PD_CTL, 16'h21f0);
        check({11'h0, deep_power_down, sleep}, 16'h001f);
        check({15'h0, irq}, 16'h0000);
        wr(`PIPD_REG_PD_CTL, 16'h2150);
        check({11'h0, deep_power_down, sleep}, 16'h0015);
        wr(`PIPD_REG_PD_CTL, 16'h2050);
        check({11'h0, deep_power_down, sleep}, 16'h0000);
        // slow management clock on the last frame
        u_sta.half = 5;
        rd_chk(`PIPD_REG_INTR_FLAGS, 16'h0600);
        link_ok = 1'b1;
        $display("test power down done");
        test_done();
    end
endmodule : pipd_top_tb
`default_nettype wire
